// ### mac_cascade_delay.sv
// Fixed-length delay line for cascade input words, stepped per sample
`timescale 1ns/100ps
module mac_cascade_delay #(
    parameter int WIDTH = mac_pkg::RES_W,
    parameter int DEPTH = mac_pkg::STAGES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stream
    input wire logic shift_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] ptr;

    // Slot at ptr was written DEPTH shifts ago
    assign data_o = mem[ptr];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr <= '0;
        end else if (shift_i) begin
            ptr <= (ptr == PTR_W'(DEPTH - 1)) ? '0 : ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (shift_i) begin
            mem[ptr] <= data_i;
        end
    end
endmodule : mac_cascade_delay

// ### mac_far_end.sv
// Far-side model: upstream device feeding cascade words and external strobes
`timescale 1ns/100ps
module mac_far_end #(
    parameter int PERIOD = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control from the bench
    input wire logic en_i,
    input wire logic [mac_pkg::RES_W-1:0] word_i,
    // Cascade and strobe
    output mac_pkg::mux_word_t cin_o,
    output logic go_o,
    output int steps_o
);
    int gap;
    logic phase;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= 1'b0;
        end else begin
            phase <= !phase;
        end
    end
    // Low half on phase 0, the same framing as the result port
    assign cin_o = {phase ? word_i[23:12] : word_i[11:0], phase};

    // Strobe idles low when disabled, as the pull-down on the shared pin would
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            steps_o <= 0;
        end else if (en_i && gap == 0) begin
            steps_o <= steps_o + 1;
        end
        if (rst_i || !en_i) begin
            gap <= 0;
            go_o <= 1'b0;
        end else begin
            go_o <= (gap == 0);
            gap <= (gap == PERIOD - 1) ? 0 : gap + 1;
        end
    end
endmodule : mac_far_end

// ### mac_out_selector.sv
// Picks the 24-bit result slice from the full sum and flags lost bits
`timescale 1ns/100ps
module mac_out_selector (
    // Full sum and slice choice
    input wire logic [mac_pkg::ACC_W-1:0] sum_i,
    input wire logic [1:0] sel_i,
    // Slice
    output logic [mac_pkg::RES_W-1:0] slice_o,
    output logic ovf_o
);
    logic signed [mac_pkg::ACC_W-1:0] shifted;
    logic [mac_pkg::ACC_W-mac_pkg::RES_W:0] top;

    always_comb begin
        shifted = $signed(sum_i) >>> (int'(sel_i) * mac_pkg::SEL_STEP);
        slice_o = shifted[mac_pkg::RES_W-1:0];
        top = shifted[mac_pkg::ACC_W-1:mac_pkg::RES_W-1];
        // Anything above the slice must be a copy of its sign bit
        ovf_o = !((&top) || !(|top));
    end
endmodule : mac_out_selector

// ### mac_pipeline.sv
// Cascadable 32-stage multiply-accumulate pipeline with Wishbone registers
//
// Behaviour
// - 32 stages multiply sample by own coefficient
// - Multiply step lasts 2 to 8 cycles
// - Products and sums kept at 36 bits
// - Sample from input port or data register
// - Result on muxed port or two registers
// - Current bank used; update bank swappable
// - Cascade input uses output port format
// - Cascade data delayed exactly 32 steps
// - Sample stream and delayed cascade summed
// - Static config written only when stopped
// - Shared strobe; master/slave role configured
// - External drivers: all slaves, strobe external; a master bit set in port mode with cascading enabled still drives its own strobe
// - Memory data: one master drives strobe
// - Lone device runs without strobe connected
// - Width code 01 selects 8-bit coefficients
// - Static bits 4,5 choose result slice
// - Partial sums until 32 samples passed
// - Overflow sets flag, drives error low
`timescale 1ns/100ps
module mac_pipeline #(
    parameter int STAGES = mac_pkg::STAGES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [mac_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    // Sample and cascade ports
    input wire logic [mac_pkg::SAMPLE_W-1:0] sample_i,
    input wire mac_pkg::mux_word_t cin_i,
    output mac_pkg::mux_word_t dout_o,
    // Synchronisation strobe pin
    input wire logic go_i,
    output logic go_o,
    output logic go_oe_o,
    // Error pin
    output logic error_n_o
);
    typedef enum logic [0:0] {IDLE, MULT} step_state_t;

    localparam int IDX_W = $clog2(STAGES);
    localparam int ADR_IDX_LSB = 2;
    localparam int ADR_BANK_LSB = ADR_IDX_LSB + IDX_W;

    step_state_t state;
    logic [mac_pkg::CNT_W-1:0] cyc_cnt;
    logic [mac_pkg::SCR_W-1:0] static_config_reg;
    logic run;
    logic swap_req;
    logic sel_ovf;
    logic cas_ovf;
    logic [mac_pkg::SAMPLE_W-1:0] dir_reg;
    logic dir_pending;
    logic [mac_pkg::SAMPLE_W-1:0] sample_q;
    logic [mac_pkg::COEF_W-1:0] coef_cur [STAGES];
    logic [mac_pkg::COEF_W-1:0] coef_upd [STAGES];
    logic [mac_pkg::ACC_W-1:0] acc [STAGES];
    logic [mac_pkg::ACC_W-1:0] next_acc [STAGES];
    logic [mac_pkg::RES_W-1:0] result;
    logic [mac_pkg::HALF_W-1:0] cin_lo;
    logic [mac_pkg::HALF_W-1:0] cin_hi;
    logic [mac_pkg::RES_W-1:0] cas_delayed;
    logic [mac_pkg::ACC_W:0] full_sum;
    logic [mac_pkg::RES_W-1:0] slice;
    logic slice_ovf;
    logic full_ovf;

    // Decoded configuration
    logic master;
    logic dir_mode;
    logic casc_en;
    logic swap_en;
    logic [1:0] cw_code;
    logic [1:0] sel_code;
    logic local_ready;
    logic start;
    logic commit;
    logic [mac_pkg::CNT_W-1:0] step_len;

    // Bus decode
    logic wb_req;
    logic wb_wr;
    logic [31:0] wr_scr;
    logic [31:0] wr_acr;
    logic [31:0] wr_dir;
    logic [IDX_W-1:0] wb_idx;
    logic [1:0] wb_bank;

    function automatic logic signed [mac_pkg::COEF_W-1:0] coef_trim(
            input logic [mac_pkg::COEF_W-1:0] c, input logic [1:0] code);
        int drop;
        logic [mac_pkg::COEF_W-1:0] up;
        // Only the low 4*(code+1) bits count; they are sign extended
        drop = mac_pkg::COEF_W - mac_pkg::CW_BITS_STEP * (int'(code) + 1);
        up = c << drop;
        return $signed(up) >>> drop;
    endfunction : coef_trim

    assign master = static_config_reg[mac_pkg::SCR_MASTER];
    assign dir_mode = static_config_reg[mac_pkg::SCR_DIR_MODE];
    assign casc_en = static_config_reg[mac_pkg::SCR_CASC_EN];
    assign swap_en = static_config_reg[mac_pkg::SCR_SWAP_EN];
    assign cw_code = static_config_reg[mac_pkg::SCR_CW_LSB +: 2];
    assign sel_code = static_config_reg[mac_pkg::SCR_SEL_LSB +: 2];
    assign step_len = mac_pkg::CNT_W'(mac_pkg::CYC_PER_CODE * (int'(cw_code) + 1));

    assign wb_req = wb_cyc_i && wb_stb_i;
    // A write lands at the edge where ack is seen high
    assign wb_wr = wb_req && wb_ack_o && wb_we_i;
    assign wb_idx = wb_adr_i[ADR_IDX_LSB +: IDX_W];
    assign wb_bank = wb_adr_i[ADR_BANK_LSB +: 2];
    assign wr_scr = mac_pkg::merge32(32'(static_config_reg), wb_dat_i, wb_sel_i);
    assign wr_acr = mac_pkg::merge32(32'h0000_0000, wb_dat_i, wb_sel_i);
    assign wr_dir = mac_pkg::merge32(32'(dir_reg), wb_dat_i, wb_sel_i);

    // Memory-interface data waits for a fresh word; port data runs every step
    assign local_ready = dir_mode ? dir_pending : 1'b1;
    always_comb begin
        start = 1'b0;
        if (run && state == IDLE) begin
            // A lone device times itself even if its master bit is set
            if (!casc_en) begin
                start = local_ready;
            end else if (master) begin
                start = go_o;
            end else begin
                start = go_i;
            end
        end
    end
    assign commit = (state == MULT) && (cyc_cnt == step_len - 1'b1);

    // Strobe: the master raises it for one cycle and starts on the same edge
    // as the slaves that see it on the shared pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_o <= 1'b0;
            go_oe_o <= 1'b0;
        end else begin
            go_oe_o <= master && casc_en;
            go_o <= master && casc_en && run && state == IDLE && !go_o && local_ready;
        end
    end

    // Step sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= IDLE;
            cyc_cnt <= '0;
        end else begin
            unique case (state)
                IDLE: begin
                    cyc_cnt <= '0;
                    if (start) begin
                        state <= MULT;
                    end
                end
                MULT: begin
                    cyc_cnt <= cyc_cnt + 1'b1;
                    if (commit) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_q <= '0;
        end else if (start) begin
            sample_q <= dir_mode ? dir_reg : sample_i;
        end
    end

    // Transposed form: the newest sample meets stage 0 at the output end
    always_comb begin
        for (int i = 0; i < STAGES; i++) begin
            logic signed [mac_pkg::ACC_W-1:0] prod;
            logic [mac_pkg::ACC_W-1:0] prev;
            // Operands widened first so the product is never cut to 16 bits
            prod = mac_pkg::ACC_W'($signed(coef_trim(coef_cur[i], cw_code)))
                   * mac_pkg::ACC_W'($signed(sample_q));
            prev = (i == STAGES - 1) ? '0 : acc[(i + 1) % STAGES];
            next_acc[i] = prev + prod;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < STAGES; i++) begin
                acc[i] <= '0;
            end
        end else if (commit) begin
            acc <= next_acc;
        end
    end

    // Cascade input halves are gathered as they pass on the muxed port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cin_lo <= '0;
            cin_hi <= '0;
        end else if (cin_i.phase) begin
            cin_hi <= cin_i.half;
        end else begin
            cin_lo <= cin_i.half;
        end
    end

    mac_cascade_delay #(
        .WIDTH(mac_pkg::RES_W),
        .DEPTH(STAGES)
    ) u_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .shift_i(commit),
        .data_i({cin_hi, cin_lo}),
        .data_o(cas_delayed)
    );

    // One extra bit catches a carry out of the cascade adder
    always_comb begin
        full_sum = {next_acc[0][mac_pkg::ACC_W-1], next_acc[0]};
        if (casc_en) begin
            full_sum = full_sum + (mac_pkg::ACC_W + 1)'($signed(cas_delayed));
        end
        full_ovf = full_sum[mac_pkg::ACC_W] != full_sum[mac_pkg::ACC_W-1];
    end

    mac_out_selector u_sel (
        .sum_i(full_sum[mac_pkg::ACC_W-1:0]),
        .sel_i(sel_code),
        .slice_o(slice),
        .ovf_o(slice_ovf)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result <= '0;
        end else if (commit) begin
            result <= slice;
        end
    end

    // Muxed output: low half with phase 0, high half with phase 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_o <= '0;
        end else begin
            dout_o.phase <= !dout_o.phase;
            dout_o.half <= dout_o.phase ? result[mac_pkg::HALF_W-1:0]
                                        : result[mac_pkg::RES_W-1:mac_pkg::HALF_W];
        end
    end

    // Static configuration only moves while stopped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            static_config_reg <= mac_pkg::SCR_RESET;
        end else if (wb_wr && wb_adr_i == mac_pkg::ADR_SCR && !run) begin
            static_config_reg <= wr_scr[mac_pkg::SCR_W-1:0];
        end
    end

    // Active control: run, swap request, sticky overflow flags (set beats clear)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run <= 1'b0;
            swap_req <= 1'b0;
            sel_ovf <= 1'b0;
            cas_ovf <= 1'b0;
        end else begin
            if (wb_wr && wb_adr_i == mac_pkg::ADR_ACR) begin
                run <= wr_acr[mac_pkg::ACR_RUN];
                if (wr_acr[mac_pkg::ACR_SEL_OVF]) begin
                    sel_ovf <= 1'b0;
                end
                if (wr_acr[mac_pkg::ACR_CAS_OVF]) begin
                    cas_ovf <= 1'b0;
                end
            end
            if (wb_wr && wb_adr_i == mac_pkg::ADR_ACR && wr_acr[mac_pkg::ACR_SWAP] && swap_en) begin
                swap_req <= 1'b1;
            end else if (commit) begin
                swap_req <= 1'b0;
            end
            if (commit && slice_ovf) begin
                sel_ovf <= 1'b1;
            end
            if (commit && full_ovf && casc_en) begin
                cas_ovf <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_n_o <= 1'b1;
        end else begin
            error_n_o <= !(sel_ovf || cas_ovf);
        end
    end

    // Input data register; a new word arms the next self-timed step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_reg <= '0;
            dir_pending <= 1'b0;
        end else if (wb_wr && wb_adr_i == mac_pkg::ADR_DIR) begin
            dir_reg <= wr_dir[mac_pkg::SAMPLE_W-1:0];
            dir_pending <= 1'b1;
        end else if (start) begin
            dir_pending <= 1'b0;
        end
    end

    // Coefficient banks; a swap at a step boundary takes precedence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < STAGES; i++) begin
                coef_cur[i] <= '0;
                coef_upd[i] <= '0;
            end
        end else if (commit && swap_req) begin
            coef_cur <= coef_upd;
            coef_upd <= coef_cur;
        end else if (wb_wr && wb_bank == mac_pkg::BANK_CUR) begin
            coef_cur[wb_idx] <= wr_dir[mac_pkg::COEF_W-1:0];
        end else if (wb_wr && wb_bank == mac_pkg::BANK_UPD) begin
            coef_upd[wb_idx] <= wr_dir[mac_pkg::COEF_W-1:0];
        end
    end

    // Wishbone answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            wb_dat_o <= '0;
            if (wb_req && !wb_ack_o && !wb_we_i) begin
                if (wb_bank == mac_pkg::BANK_CUR) begin
                    wb_dat_o <= 32'(coef_cur[wb_idx]);
                end else if (wb_bank == mac_pkg::BANK_UPD) begin
                    wb_dat_o <= 32'(coef_upd[wb_idx]);
                end else begin
                    unique case (wb_adr_i)
                        mac_pkg::ADR_SCR: wb_dat_o <= 32'(static_config_reg);
                        mac_pkg::ADR_ACR: wb_dat_o <= 32'({run, cas_ovf, sel_ovf, swap_req});
                        mac_pkg::ADR_DIR: wb_dat_o <= 32'(dir_reg);
                        mac_pkg::ADR_DOL: wb_dat_o <= 32'(result[mac_pkg::HALF_W-1:0]);
                        mac_pkg::ADR_DOH: wb_dat_o <= 32'(result[mac_pkg::RES_W-1:mac_pkg::HALF_W]);
                        default: wb_dat_o <= '0;
                    endcase
                end
            end
        end
    end
endmodule : mac_pipeline

// ### mac_pipeline_assertions.sv
// Concurrent checks on the ports of the MAC pipeline
`timescale 1ns/100ps
module mac_pipeline_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic [mac_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_ack_o,
    // Pins
    input wire mac_pkg::mux_word_t dout_o,
    input wire logic go_o,
    input wire logic go_oe_o,
    input wire logic error_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_acr_read;
        wb_ack_o && !wb_we_i && wb_adr_i == mac_pkg::ADR_ACR;
    endsequence

    AST_ACK_PULSE: assert property (s_taken |=> s_ack_pulse)
        else $error("ack not a single pulse one cycle after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    AST_ERR_FLAGS: assert property (s_acr_read |-> error_n_o == !(wb_dat_o[1] || wb_dat_o[2]))
        else $error("error pin disagrees with overflow flags");
    AST_GO_ROLE: assert property (go_o |-> go_oe_o)
        else $error("strobe driven while not master");
    AST_GO_SPACING: assert property (go_o |=> !go_o [*3])
        else $error("strobes closer than the shortest step");
    // Guard two cycles so the reset value of the phase is never compared
    AST_PHASE: assert property (!$past(rst_i) && !$past(rst_i, 2)
        |-> dout_o.phase != $past(dout_o.phase))
        else $error("output phase did not toggle");
    AST_OE_CAUSE: assert property ($changed(go_oe_o)
        |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
        else $error("strobe role changed without a write");
endmodule : mac_pipeline_checker

bind mac_pipeline mac_pipeline_checker i_mac_pipeline_checker (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .dout_o(dout_o), .go_o(go_o),
    .go_oe_o(go_oe_o), .error_n_o(error_n_o));

// ### mac_pipeline_tb_top.sv
// Self-checking bench for the MAC pipeline
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module mac_pipeline_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [8:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack, go_o, go_oe_o, error_n_o, far_go;
    logic en = 1'b0;
    logic [15:0] sample = '0;
    logic [23:0] word = '0;
    mac_pkg::mux_word_t cin, dout;
    int n_mismatch = 0;
    int num_checks = 0;
    int steps;

    always #25 clk_i = ~clk_i;

    mac_pipeline i_mac_pipeline (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb), .wb_cyc_i(cyc),
        .wb_ack_o(ack), .sample_i(sample), .cin_i(cin), .dout_o(dout),
        .go_i(go_oe_o ? go_o : far_go), .go_o(go_o), .go_oe_o(go_oe_o), .error_n_o(error_n_o));
    mac_far_end i_mac_far_end (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .word_i(word),
        .cin_o(cin), .go_o(far_go), .steps_o(steps));

    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        if (n >= 20) begin
            n_mismatch++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(got, e)
    endtask : rd

    // A data register write arms one step; 12 cycles outlast the 8-cycle worst case
    task automatic step(input logic [31:0] v);
        wr(mac_pkg::ADR_DIR, v);
        repeat (12) @(posedge clk_i);
    endtask : step

    task automatic upto(input int k);
        int n;
        n = 0;
        while (steps < k && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        en <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : upto

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(error_n_o, 1'b1)
        `CHK(go_oe_o, 1'b0)
        rd(mac_pkg::ADR_SCR, 32'h0000_0000);
        rd(9'h040, 32'h0000_0000);
        $display("test reset done");
        // Self-timed data register mode, strobe pin left idle
        wr(mac_pkg::ADR_SCR, 32'h0000_0102);
        wr(9'h080, 32'h0000_0103);
        wr(9'h084, 32'h0000_0002);
        wr(mac_pkg::ADR_ACR, 32'h0000_0008);
        wr(mac_pkg::ADR_SCR, 32'h0000_0000);
        rd(mac_pkg::ADR_SCR, 32'h0000_0102);
        step(32'h0000_0005);
        rd(mac_pkg::ADR_DOL, 32'h0000_000F);
        step(32'h0000_0007);
        rd(mac_pkg::ADR_DOL, 32'h0000_001F);
        rd(mac_pkg::ADR_DOH, 32'h0000_0000);
        $display("test data register done");
        wr(mac_pkg::ADR_ACR, 32'h0000_0000);
        wr(mac_pkg::ADR_SCR, 32'h0000_0112);
        wr(mac_pkg::ADR_ACR, 32'h0000_0008);
        step(32'h0000_0100);
        rd(mac_pkg::ADR_DOL, 32'h0000_0030);
        $display("test selector done");
        wr(mac_pkg::ADR_ACR, 32'h0000_0000);
        wr(mac_pkg::ADR_SCR, 32'h0000_0302);
        wr(9'h080, 32'h0000_7FFF);
        wr(mac_pkg::ADR_ACR, 32'h0000_0008);
        step(32'h0000_7FFF);
        `CHK(error_n_o, 1'b0)
        rd(mac_pkg::ADR_ACR, 32'h0000_000A);
        wr(mac_pkg::ADR_ACR, 32'h0000_000A);
        repeat (2) @(posedge clk_i);
        rd(mac_pkg::ADR_ACR, 32'h0000_0008);
        `CHK(error_n_o, 1'b1)
        $display("test overflow done");
        // Bank swap lands at the next step end; that step still uses the old bank
        wr(mac_pkg::ADR_ACR, 32'h0000_0000);
        wr(mac_pkg::ADR_SCR, 32'h0000_0502);
        wr(9'h100, 32'h0000_0004);
        rd(9'h100, 32'h0000_0004);
        wr(mac_pkg::ADR_ACR, 32'h0000_0009);
        rd(mac_pkg::ADR_ACR, 32'h0000_0009);
        step(32'h0000_0001);
        rd(mac_pkg::ADR_DOL, 32'h0000_0FFD);
        rd(mac_pkg::ADR_ACR, 32'h0000_0008);
        rd(9'h100, 32'h0000_7FFF);
        step(32'h0000_0001);
        rd(mac_pkg::ADR_DOL, 32'h0000_0006);
        $display("test swap done");
        // Slave with external strobes; cascade word must wait 32 steps
        wr(mac_pkg::ADR_ACR, 32'h0000_0000);
        wr(mac_pkg::ADR_SCR, 32'h0000_0104);
        wr(9'h080, 32'h0000_0003);
        wr(9'h084, 32'h0000_0000);
        sample <= 16'h0002;
        word <= 24'h01_2345;
        wr(mac_pkg::ADR_ACR, 32'h0000_0008);
        en <= 1'b1;
        upto(10);
        rd(mac_pkg::ADR_DOL, 32'h0000_0006);
        rd(mac_pkg::ADR_DOH, 32'h0000_0000);
        en <= 1'b1;
        upto(40);
        rd(mac_pkg::ADR_DOL, 32'h0000_034B);
        rd(mac_pkg::ADR_DOH, 32'h0000_0012);
        @(posedge clk_i);
        if (dout.phase) begin
            @(posedge clk_i);
        end
        `CHK(dout.half, 12'h34B)
        @(posedge clk_i);
        `CHK(dout, {12'h012, 1'b1})
        $display("test cascade done");
        wr(mac_pkg::ADR_ACR, 32'h0000_0000);
        wr(mac_pkg::ADR_SCR, 32'h0000_0105);
        // A new sample shows that the master's own strobe advanced the pipeline
        sample <= 16'h0004;
        wr(mac_pkg::ADR_ACR, 32'h0000_0008);
        repeat (40) @(posedge clk_i);
        `CHK(go_oe_o, 1'b1)
        rd(mac_pkg::ADR_DOL, 32'h0000_0351);
        rd(mac_pkg::ADR_DOH, 32'h0000_0012);
        $display("test master done");
        conclude();
    end

    // Whole sequence needs under a thousand cycles; allow 40000 of them
    initial begin
        #(50 * 40000);
        n_mismatch++;
        conclude();
    end
endmodule : mac_pipeline_tb_top

// ### mac_pkg.sv
// Shared constants, register map and carrier types of the MAC pipeline
package mac_pkg;
    // Array geometry
    localparam int STAGES = 32;
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 16;
    localparam int ACC_W = 36;
    localparam int RES_W = 24;
    localparam int HALF_W = 12;
    localparam int ADR_W = 9;
    localparam int SCR_W = 11;
    localparam int ACR_W = 4;
    localparam int CNT_W = 4;

    // Register byte addresses
    localparam logic [ADR_W-1:0] ADR_SCR = 9'h000;
    localparam logic [ADR_W-1:0] ADR_ACR = 9'h004;
    localparam logic [ADR_W-1:0] ADR_DIR = 9'h008;
    localparam logic [ADR_W-1:0] ADR_DOL = 9'h00C;
    localparam logic [ADR_W-1:0] ADR_DOH = 9'h010;
    localparam logic [1:0] BANK_CUR = 2'h1;
    localparam logic [1:0] BANK_UPD = 2'h2;

    // static_config_reg fields
    localparam int SCR_MASTER = 0;
    localparam int SCR_DIR_MODE = 1;
    localparam int SCR_CASC_EN = 2;
    localparam int SCR_SEL_LSB = 4;
    localparam int SCR_CW_LSB = 8;
    localparam int SCR_SWAP_EN = 10;
    localparam logic [SCR_W-1:0] SCR_RESET = 11'h000;

    // active_control_reg fields
    localparam int ACR_SWAP = 0;
    localparam int ACR_SEL_OVF = 1;
    localparam int ACR_CAS_OVF = 2;
    localparam int ACR_RUN = 3;

    // Coefficient width code n gives 4*(n+1) bits and 2*(n+1) cycles per step
    localparam int CW_BITS_STEP = 4;
    localparam int CYC_PER_CODE = 2;
    // Selector code n shifts the result right by 4*n bits
    localparam int SEL_STEP = 4;

    // One half of a 24-bit result on a multiplexed port
    typedef struct packed {
        logic [HALF_W-1:0] half;
        logic phase;
    } mux_word_t;

    function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge32
endpackage : mac_pkg
